// ### src/pxc_pkg.sv
package pxc_pkg;
    // dword offsets in configuration space
    localparam logic [7:0] CAP_DWORD_OFF = 8'he4;
    localparam logic [7:0] STATUS_DWORD_OFF = 8'he8;
    localparam logic [7:0] CAP_ID_VALUE = 8'h07;
    localparam logic [7:0] NEXT_CAP_VALUE = 8'hf0;
    localparam logic [7:0] NEXT_CAP_NONE = 8'h00;
    // command field positions
    localparam int CMD_PARITY_BIT = 0;
    localparam int CMD_RELAXED_BIT = 1;
    localparam int CMD_RDCNT_LO = 2;
    localparam int CMD_SPLIT_LO = 4;
    localparam logic CMD_PARITY_RESET = 1'b0;
    localparam logic CMD_RELAXED_RESET = 1'b1;
    localparam logic [1:0] CMD_RDCNT_RESET = 2'h0;
    localparam logic [2:0] CMD_SPLIT_RESET = 3'h0;
    // status field positions
    localparam int STS_DEV_LO = 3;
    localparam int STS_BUS_LO = 8;
    localparam int STS_WIDE_BIT = 16;
    localparam int STS_FAST_BIT = 17;
    localparam int STS_DISCARD_BIT = 18;
    localparam int STS_UNEXP_BIT = 19;
    localparam int STS_BRIDGE_BIT = 20;
    localparam int STS_DESIGN_LO = 21;
    localparam logic [2:0] FUNC_RESET = 3'h0;
    localparam logic [4:0] DEV_RESET = 5'h1f;
    localparam logic [7:0] BUS_RESET = 8'hff;
    localparam logic [1:0] DESIGN_RDCNT = 2'h2;
    localparam logic BRIDGE_VALUE = 1'b0;
    // configuration byte enable index for command bytes
    localparam int CMD_BYTE_LO = 2;
    localparam int CMD_BYTE_HI = 3;
    // outstanding split transactions the engine is built for
    localparam logic [5:0] SPLIT_HW_MAX = 6'h01;
endpackage

// ### src/pxc_decode.sv
`timescale 1ns/1ns
// code tables: read byte count and split limit
module pxc_decode (
    // codes
    input wire logic [1:0] rdcnt_code,
    input wire logic [2:0] split_code,
    // decoded values
    output logic [12:0] rdcnt_bytes,
    output logic [5:0] split_limit
);
    assign rdcnt_bytes = 13'h0200 << rdcnt_code;
    always_comb
    begin
        case (split_code)
            3'h0: split_limit = 6'h01;
            3'h1: split_limit = 6'h02;
            3'h2: split_limit = 6'h03;
            3'h3: split_limit = 6'h04;
            3'h4: split_limit = 6'h08;
            3'h5: split_limit = 6'h0c;
            3'h6: split_limit = 6'h10;
            3'h7: split_limit = 6'h20;
            default: split_limit = 6'h01;
        endcase
    end
endmodule

// ### src/pxc_regs.sv
`timescale 1ns/1ns
module pxc_regs (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // configuration access
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic cfg_type0,
    input wire logic [7:0] cfg_dword_addr,
    input wire logic [3:0] cfg_byte_en,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_ad_addr,
    output logic [31:0] cfg_rdata,
    output logic cfg_hit,
    // mode and nonvolatile settings
    input wire logic pcix_mode,
    input wire logic nv_msi_disable,
    input wire logic nv_wide_bus,
    input wire logic nv_fast_clock,
    input wire logic [2:0] function_number,
    // parity and system error
    input wire logic serr_enable,
    input wire logic master_parity_status,
    output logic serr_request,
    output logic parity_recovery_active,
    // transaction engine
    input wire logic split_discard_event,
    input wire logic unexpected_split_event,
    input wire logic split_issue,
    input wire logic split_complete,
    output logic split_allowed,
    output logic relaxed_order_active,
    output logic [12:0] read_byte_limit,
    output logic [5:0] split_limit,
    output logic [15:0] requester_id
);
    logic parity_recovery_enable_reg;
    logic relaxed_order_enable_reg;
    logic [1:0] rdcnt_reg;
    logic [2:0] split_reg;
    logic [4:0] dev_reg;
    logic [7:0] bus_reg;
    logic split_discard_flag_reg;
    logic unexpected_split_flag_reg;
    logic [5:0] outstanding_reg;
    logic [5:0] outstanding_next;
    logic [31:0] rdata_reg;
    logic [12:0] rdcnt_bytes;
    logic [5:0] split_code_limit;

    wire cap_hit = cfg_dword_addr == pxc_pkg::CAP_DWORD_OFF;
    wire sts_hit = cfg_dword_addr == pxc_pkg::STATUS_DWORD_OFF;
    wire cmd_wr_lo = cfg_write && cap_hit && cfg_byte_en[pxc_pkg::CMD_BYTE_LO];
    wire sts_clr = cfg_write && sts_hit && cfg_byte_en[pxc_pkg::CMD_BYTE_LO];
    wire id_capture = cfg_write && cfg_type0;
    wire hide_msi = !pcix_mode && nv_msi_disable;
    wire [7:0] next_ptr = hide_msi ? pxc_pkg::NEXT_CAP_NONE : pxc_pkg::NEXT_CAP_VALUE;
    // command bits 15:7 are not stored; they read zero
    wire [15:0] cmd_word = {9'h000, split_reg, rdcnt_reg,
                            relaxed_order_enable_reg, parity_recovery_enable_reg};
    wire [31:0] cap_word = {cmd_word, next_ptr, pxc_pkg::CAP_ID_VALUE};
    wire [31:0] sts_word = {9'h000, pxc_pkg::DESIGN_RDCNT, pxc_pkg::BRIDGE_VALUE,
                            unexpected_split_flag_reg, split_discard_flag_reg,
                            nv_fast_clock, nv_wide_bus,
                            bus_reg, dev_reg, function_number};
    wire [31:0] rdata_next = cap_hit ? cap_word : (sts_hit ? sts_word : 32'h0000_0000);

    pxc_decode u_decode (
        .rdcnt_code(rdcnt_reg),
        .split_code(split_reg),
        .rdcnt_bytes(rdcnt_bytes),
        .split_limit(split_code_limit)
    );

    // parity recovery, relaxed ordering and serr act only in PCI-X mode; read byte and split limits apply in both modes
    assign parity_recovery_active = pcix_mode && parity_recovery_enable_reg;
    assign relaxed_order_active = pcix_mode && relaxed_order_enable_reg;
    assign read_byte_limit = rdcnt_bytes;
    assign split_limit = split_code_limit;
    assign serr_request = pcix_mode && !parity_recovery_enable_reg
                          && master_parity_status && serr_enable;
    // hardware is built for one split at a time whatever the programmed limit
    assign split_allowed = outstanding_reg < pxc_pkg::SPLIT_HW_MAX;
    assign outstanding_next = outstanding_reg + 6'((split_issue && split_allowed) ? 1 : 0)
                              - 6'((split_complete && outstanding_reg != 6'h00) ? 1 : 0);
    assign requester_id = {bus_reg, dev_reg, function_number};
    assign cfg_hit = cap_hit || sts_hit;
    assign cfg_rdata = rdata_reg;

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            parity_recovery_enable_reg <= pxc_pkg::CMD_PARITY_RESET;
            relaxed_order_enable_reg <= pxc_pkg::CMD_RELAXED_RESET;
            rdcnt_reg <= pxc_pkg::CMD_RDCNT_RESET;
            split_reg <= pxc_pkg::CMD_SPLIT_RESET;
        end
        else if (cmd_wr_lo)
        begin
            parity_recovery_enable_reg <= cfg_wdata[16 + pxc_pkg::CMD_PARITY_BIT];
            relaxed_order_enable_reg <= cfg_wdata[16 + pxc_pkg::CMD_RELAXED_BIT];
            rdcnt_reg <= cfg_wdata[16 + pxc_pkg::CMD_RDCNT_LO +: 2];
            split_reg <= cfg_wdata[16 + pxc_pkg::CMD_SPLIT_LO +: 3];
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            dev_reg <= pxc_pkg::DEV_RESET;
            bus_reg <= pxc_pkg::BUS_RESET;
        end
        else if (id_capture)
        begin
            dev_reg <= cfg_ad_addr[15:11];
            bus_reg <= cfg_ad_addr[7:0];
        end
    end

    // a new event in the clearing cycle wins over the clear
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            split_discard_flag_reg <= 1'b0;
            unexpected_split_flag_reg <= 1'b0;
        end
        else
        begin
            split_discard_flag_reg <= split_discard_event || (split_discard_flag_reg
                && !(sts_clr && cfg_wdata[pxc_pkg::STS_DISCARD_BIT]));
            unexpected_split_flag_reg <= unexpected_split_event || (unexpected_split_flag_reg
                && !(sts_clr && cfg_wdata[pxc_pkg::STS_UNEXP_BIT]));
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            outstanding_reg <= 6'h00;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            outstanding_reg <= outstanding_next;
            if (cfg_read)
            begin
                rdata_reg <= rdata_next;
            end
        end
    end

    a_split_single: assert property (@(posedge clock) disable iff (rst)
        outstanding_reg <= pxc_pkg::SPLIT_HW_MAX) else $error("split over one");
    a_split_block: assert property (@(posedge clock) disable iff (rst)
        outstanding_reg != 6'h00 |-> !split_allowed) else $error("split not blocked");
    a_discard_set: assert property (@(posedge clock) disable iff (rst)
        split_discard_event |=> split_discard_flag_reg) else $error("discard lost");
    a_unexp_set: assert property (@(posedge clock) disable iff (rst)
        unexpected_split_event |=> unexpected_split_flag_reg) else $error("unexp lost");
    a_discard_clear: assert property (@(posedge clock) disable iff (rst)
        sts_clr && cfg_wdata[pxc_pkg::STS_DISCARD_BIT] && !split_discard_event
        |=> !split_discard_flag_reg) else $error("discard not cleared");
    a_id_capture: assert property (@(posedge clock) disable iff (rst)
        id_capture |=> requester_id[15:3] == {$past(cfg_ad_addr[7:0]), $past(cfg_ad_addr[15:11])})
        else $error("id not captured");
    a_serr_gate: assert property (@(posedge clock) disable iff (rst)
        serr_request |-> serr_enable && master_parity_status && !parity_recovery_active)
        else $error("serr ungated");
    a_cap_read: assert property (@(posedge clock) disable iff (rst)
        cfg_read && cap_hit |=> cfg_rdata[7:0] == pxc_pkg::CAP_ID_VALUE && cfg_rdata[31:23] == 9'h000)
        else $error("cap word wrong");
    a_next_hidden: assert property (@(posedge clock) disable iff (rst)
        cfg_read && cap_hit && hide_msi |=> cfg_rdata[15:8] == 8'h00)
        else $error("next not hidden");
    a_mode_gate: assert property (@(posedge clock) disable iff (rst)
        !pcix_mode |-> !relaxed_order_active && !serr_request) else $error("mode leak");
endmodule

// ### verif/pxc_engine_model.sv
`timescale 1ns/1ns
// split engine stand-in: one request in flight, completes after a fixed wait
module pxc_engine_model #(parameter int LAT = 4) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic go,
    input wire logic split_allowed,
    // engine pulses
    output logic split_issue,
    output logic split_complete
);
    logic [3:0] wait_reg;
    logic busy_reg;
    always_ff @(posedge clock)
    begin
        split_issue <= 1'b0;
        split_complete <= 1'b0;
        if (rst)
            busy_reg <= 1'b0;
        else if (busy_reg)
        begin
            wait_reg <= wait_reg + 4'h1;
            busy_reg <= (wait_reg != 4'(LAT));
            split_complete <= (wait_reg == 4'(LAT));
        end
        // issue only when the block allows it
        else if (go && split_allowed)
        begin
            split_issue <= 1'b1;
            busy_reg <= 1'b1;
            wait_reg <= 4'h0;
        end
    end
endmodule

// ### verif/pcix_capability_registers_tb.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module pcix_capability_registers_tb;
    logic clock = 0, rst = 1, cfg_write = 0, cfg_read = 0, cfg_type0 = 0;
    logic [7:0] cfg_dword_addr = 8'he4;
    logic [3:0] cfg_byte_en = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_ad_addr = 32'h0, cfg_rdata, rd;
    logic cfg_hit, pcix_mode = 1, nv_msi_disable = 0, nv_wide_bus = 1, nv_fast_clock = 1;
    logic [2:0] function_number = 3'h5;
    logic serr_enable = 0, master_parity_status = 0, serr_request, parity_recovery_active;
    logic split_discard_event = 0, unexpected_split_event = 0, split_issue, split_complete;
    logic split_allowed, relaxed_order_active, go = 0;
    logic [12:0] read_byte_limit;
    logic [5:0] split_limit;
    logic [15:0] requester_id;
    logic [5:0] lim [8] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};
    int fail_count = 0, compares = 0, cycles = 0;
    always #50 clock = ~clock;
    pxc_regs dut (.clock, .rst, .cfg_write, .cfg_read, .cfg_type0, .cfg_dword_addr,
        .cfg_byte_en, .cfg_wdata, .cfg_ad_addr, .cfg_rdata, .cfg_hit, .pcix_mode,
        .nv_msi_disable, .nv_wide_bus, .nv_fast_clock, .function_number, .serr_enable,
        .master_parity_status, .serr_request, .parity_recovery_active, .split_discard_event,
        .unexpected_split_event, .split_issue, .split_complete, .split_allowed,
        .relaxed_order_active, .read_byte_limit, .split_limit, .requester_id);
    pxc_engine_model eng (.clock, .rst, .go, .split_allowed, .split_issue, .split_complete);
    task step;
        @(posedge clock);
        #10;
    endtask
    task cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d, input logic t0);
        cfg_dword_addr = a;
        cfg_byte_en = be;
        cfg_wdata = d;
        cfg_type0 = t0;
        cfg_write = 1;
        step;
        cfg_write = 0;
        cfg_type0 = 0;
    endtask
    task cfg_rd(input logic [7:0] a, output logic [31:0] d);
        cfg_dword_addr = a;
        cfg_read = 1;
        step;
        cfg_read = 0;
        d = cfg_rdata;
    endtask
    task t_reset;
        cfg_rd(8'he4, rd);
        `CHK("cap dword", 32'h0002_f007, rd)
        cfg_rd(8'he8, rd);
        `CHK("status", 23'h43_fffd, rd[22:0])
        cfg_rd(8'h40, rd);
        `CHK("unmapped", 32'h0, rd)
        `CHK("hit", 1'b0, cfg_hit)
        $display("reset test done");
    endtask
    task t_command;
        cfg_wr(8'he4, 4'hc, 32'hffff_0000, 0);
        cfg_rd(8'he4, rd);
        `CHK("cmd", 32'h007f_f007, rd)
        `CHK("relaxed on", 1'b1, relaxed_order_active)
        pcix_mode = 0;
        step;
        `CHK("relaxed off", 1'b0, relaxed_order_active)
        `CHK("recovery off", 1'b0, parity_recovery_active)
        pcix_mode = 1;
        cfg_wr(8'he4, 4'h3, 32'h0000_ffff, 0);
        cfg_rd(8'he4, rd);
        `CHK("no byte2", 32'h007f_f007, rd)
        for (int i = 0; i < 8; i++)
        begin
            cfg_wr(8'he4, 4'hc, {9'h0, i[2:0], i[1:0], 2'h0, 16'h0}, 0);
            `CHK("read bytes", 13'h0200 << i[1:0], read_byte_limit)
            `CHK("split limit", lim[i], split_limit)
        end
        $display("command test done");
    endtask
    task t_ident;
        cfg_ad_addr = 32'h0000_a85a;
        cfg_wr(8'he8, 4'h0, 32'h0, 1);
        cfg_ad_addr = 32'h0000_0000;
        cfg_wr(8'he8, 4'h0, 32'h0, 0);
        nv_wide_bus = 0;
        cfg_rd(8'he8, rd);
        `CHK("bus dev func", 16'h5aad, rd[15:0])
        `CHK("hit status", 1'b1, cfg_hit)
        `CHK("requester", 16'h5aad, requester_id)
        `CHK("caps", 2'h2, rd[17:16])
        $display("identity test done");
    endtask
    task t_flags;
        split_discard_event = 1;
        unexpected_split_event = 1;
        step;
        split_discard_event = 0;
        unexpected_split_event = 0;
        cfg_rd(8'he8, rd);
        `CHK("flags set", 3'h3, rd[20:18])
        cfg_wr(8'he8, 4'h4, 32'h0004_0000, 0);
        cfg_rd(8'he8, rd);
        `CHK("discard clr", 2'h2, rd[19:18])
        cfg_wr(8'he8, 4'h4, 32'h0008_0000, 0);
        cfg_rd(8'he8, rd);
        `CHK("unexp clr", 2'h0, rd[19:18])
        split_discard_event = 1;
        cfg_wr(8'he8, 4'h4, 32'h0004_0000, 0);
        split_discard_event = 0;
        cfg_rd(8'he8, rd);
        `CHK("set beats clr", 1'b1, rd[18])
        cfg_wr(8'he8, 4'h4, 32'h0004_0000, 0);
        cfg_rd(8'he8, rd);
        `CHK("discard clr2", 1'b0, rd[18])
        $display("flag test done");
    endtask
    task t_nextcap;
        pcix_mode = 0;
        nv_msi_disable = 1;
        cfg_rd(8'he4, rd);
        `CHK("next none", 16'h0007, rd[15:0])
        pcix_mode = 1;
        cfg_rd(8'he4, rd);
        `CHK("next pcix", 8'hf0, rd[15:8])
        nv_msi_disable = 0;
        $display("next pointer test done");
    endtask
    task t_serr;
        serr_enable = 1;
        master_parity_status = 1;
        step;
        `CHK("serr on", 1'b1, serr_request)
        serr_enable = 0;
        step;
        `CHK("serr gated", 1'b0, serr_request)
        serr_enable = 1;
        cfg_wr(8'he4, 4'hc, 32'h0001_0000, 0);
        `CHK("serr recov", 1'b0, serr_request)
        `CHK("recovery", 1'b1, parity_recovery_active)
        master_parity_status = 0;
        $display("system error test done");
    endtask
    task t_split;
        go = 1;
        for (int k = 0; k < 20 && split_issue !== 1'b1; k++) step;
        go = 0;
        step;
        `CHK("one split", 1'b0, split_allowed)
        for (int k = 0; k < 20 && split_complete !== 1'b1; k++) step;
        step;
        `CHK("split free", 1'b1, split_allowed)
        $display("split test done");
    endtask
    task test_done;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ceiling well above the fewer than a hundred cycles the tests need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fail_count++;
            test_done;
        end
    end
    initial
    begin
        repeat (16) @(posedge clock);
        #10 rst = 0;
        t_reset;
        t_command;
        t_ident;
        t_flags;
        t_nextcap;
        t_serr;
        t_split;
        test_done;
    end
endmodule
